/* hw/clk_setup_defs.vh */
// Purpose: constants for the transceiver clock setup block
// Assumes: 200 MHz mclk, Avalon-MM register slave with byte addresses
// Notes:   offsets are byte addresses, one 32-bit word per register
//
// What this block does
// - source over (ratio+1) equals 64 times IF
// - generator makes 38.4 MHz from reference
// - prescale divides input by count plus one
// - data clock is source/(divider+1)/128
// - select cleared takes source from oscillator
// - reference select picks 800 kHz or 1.2 MHz
// - compare frequency is crystal/(ref_divider+1)
// - sleep while power pin low, else standby
// - bias or synth enable gates oscillator, synth enable alone gates PLL, in standby
// - wait state checks synth register changes
// - ADC clocked from the selected source
// - settling delay after synth change
`ifndef CLK_SETUP_DEFS_VH
`define CLK_SETUP_DEFS_VH

// ************************************************************
// register byte offsets
// ************************************************************
`define OFS_CLOCK    8'h00
`define OFS_SYNTH1   8'h04
`define OFS_SYNTH2   8'h08
`define OFS_SYNTH3   8'h0c
`define OFS_SYNTH4   8'h10
`define OFS_MODE     8'h14
`define OFS_STATUS   8'h18

// ************************************************************
// reset values
// ************************************************************
`define RST_CLOCK    32'h0000_0000
`define RST_SYNTH1   32'h0000_0000
`define RST_SYNTH2   32'h0000_0000
`define RST_SYNTH3   32'h0000_0000
`define RST_SYNTH4   32'h0000_0000
`define RST_MODE     32'h0000_0000

// ************************************************************
// fields of the clock register
// ************************************************************
`define F_RATIO_LO   0
`define F_RATIO_HI   4
`define F_PRE_LO     8
`define F_PRE_HI     12
`define F_DRD_LO     16
`define F_DRD_HI     22
`define F_CGSEL      24
`define F_REFSEL     25
`define F_OSCEN      26

// fields of synth registers and mode register
`define F_REFDIV_LO  0
`define F_REFDIV_HI  3
`define F_VCOSEL     4
`define F_SETTLE_LO  8
`define F_SETTLE_HI  10
`define F_INT_LO     0
`define F_INT_HI     7
`define F_FRAC_LO    0
`define F_FRAC_HI    15
`define F_BIAS       0
`define F_SYNTH      1
`define F_TRX        2

// ************************************************************
// fixed divisions and timing
// ************************************************************
`define IF_OVERSAMPLE 64
`define DR_POSTDIV    128
`define CLK_MHZ       200
`define SETTLE_UNIT_US 10
`define SETTLE_UNIT_CYC (`SETTLE_UNIT_US * `CLK_MHZ)

`endif

/* hw/clk_divider.v */
// Purpose: programmable divider producing one-cycle ticks
// Assumes: enable held high while dividing
// Notes:   divides by div+1; reloading on disable keeps phase known
`timescale 1ns/1ps
`default_nettype none
module clk_divider #(
  parameter W = 8
) (
  // clock and reset
  input  wire         mclk,
  input  wire         rstn,
  // control
  input  wire         en,
  input  wire [W-1:0] div,
  // output tick
  output reg          tick
);
  reg [W-1:0] count;

  // count down from div, tick at zero
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      count <= {W{1'b0}};
      tick  <= 1'b0;
    end else if (!en) begin
      count <= div;
      tick  <= 1'b0;
    end else if (count == {W{1'b0}}) begin
      count <= div;
      tick  <= 1'b1;
    end else begin
      count <= count - {{(W-1){1'b0}}, 1'b1};
      tick  <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* hw/clk_setup.v */
// Purpose: clock source selection, IF and data-rate dividers, power-state entry
// Assumes: osc_tick and pll_tick are one-cycle strobes at source rates
// Notes:   clocks here are enables on mclk; the analog parts follow them
`include "clk_setup_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module clk_setup #(
  parameter SETTLE_UNIT_CYC = `SETTLE_UNIT_CYC
) (
  // clock and reset
  input  wire        mclk,
  input  wire        rstn,
  // avalon-mm slave
  input  wire [7:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  input  wire [3:0]  byteenable,
  output reg  [31:0] readdata,
  output wire        waitrequest,
  // reference ticks from the analog front end
  input  wire        osc_tick,
  input  wire        pll_tick,
  // pins
  input  wire        power_on_pin,
  // analog controls
  output reg         osc_on,
  output reg         bandgap_on,
  output reg         pll_on,
  output reg         clockgen_on,
  output reg         clockgen_reference,
  // derived clocks as tick strobes
  output wire        source_tick,
  output wire        adc_tick,
  output wire        clockgen_tick,
  output wire        if_tick,
  output wire        data_rate_tick,
  // state
  output reg  [1:0]  power_state,
  output reg         trx_ready
);
  // states
  localparam ST_SLEEP   = 2'd0;
  localparam ST_STANDBY = 2'd1;
  localparam ST_WAIT    = 2'd2;
  localparam ST_TRX     = 2'd3;

  // ************************************************************
  // registers
  // ************************************************************
  reg  [31:0] clock_reg;
  reg  [31:0] synth1;
  reg  [31:0] synth2;
  reg  [31:0] synth3;
  reg  [31:0] synth4;
  reg  [31:0] mode_reg;
  reg         synth_changed;
  reg         ack;
  reg  [31:0] next_readdata;

  wire        sel_c  = (address == `OFS_CLOCK);
  wire        sel_1  = (address == `OFS_SYNTH1);
  wire        sel_2  = (address == `OFS_SYNTH2);
  wire        sel_3  = (address == `OFS_SYNTH3);
  wire        sel_4  = (address == `OFS_SYNTH4);
  wire        sel_m  = (address == `OFS_MODE);
  wire        wr_go  = write && ack;   // lands at the answering edge only
  wire        rd_go  = read && !ack;
  wire [31:0] bmask  = {{8{byteenable[3]}}, {8{byteenable[2]}},
                        {8{byteenable[1]}}, {8{byteenable[0]}}};

  // one wait cycle per access; answer arrives on the next edge
  assign waitrequest = (read || write) && !ack;

  // acknowledge toggle so each access takes exactly two edges
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ack <= 1'b0;
    end else begin
      ack <= (read || write) && !ack;
    end
  end

  // register writes honour byte enables
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      clock_reg <= `RST_CLOCK;
      synth1    <= `RST_SYNTH1;
      synth2    <= `RST_SYNTH2;
      synth3    <= `RST_SYNTH3;
      synth4    <= `RST_SYNTH4;
      mode_reg  <= `RST_MODE;
    end else if (wr_go) begin
      if (sel_c) clock_reg <= (clock_reg & ~bmask) | (writedata & bmask);
      // divider words kept for the PLL
      if (sel_1) synth1 <= (synth1 & ~bmask) | (writedata & bmask);
      if (sel_2) synth2 <= (synth2 & ~bmask) | (writedata & bmask);
      if (sel_3) synth3 <= (synth3 & ~bmask) | (writedata & bmask);
      if (sel_4) synth4 <= (synth4 & ~bmask) | (writedata & bmask);
      if (sel_m) mode_reg <= (mode_reg & ~bmask) | (writedata & bmask);
    end
  end

  // change detect
  // any write touching a synth register marks it changed; the set wins
  // over the clear taken when the wait state consumes the flag
  wire synth_wr = wr_go && (sel_1 || sel_2 || sel_3 || sel_4) && (byteenable != 4'h0);
  wire consume;
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      synth_changed <= 1'b0;
    end else if (synth_wr) begin
      synth_changed <= 1'b1;
    end else if (consume) begin
      synth_changed <= 1'b0;
    end
  end

  // read mux; unmapped addresses read zero
  always @* begin
    next_readdata = 32'h0000_0000;
    case (address)
      `OFS_CLOCK:  next_readdata = clock_reg;
      `OFS_SYNTH1: next_readdata = synth1;
      `OFS_SYNTH2: next_readdata = synth2;
      `OFS_SYNTH3: next_readdata = synth3;
      `OFS_SYNTH4: next_readdata = synth4;
      `OFS_MODE:   next_readdata = mode_reg;
      `OFS_STATUS: next_readdata = {26'h0, synth_changed, trx_ready, pll_on,
                                    osc_on, power_state};
      default:     next_readdata = 32'h0000_0000;
    endcase
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      readdata <= 32'h0000_0000;
    end else if (rd_go) begin
      readdata <= next_readdata;
    end
  end

  // ************************************************************
  // field decode
  // ************************************************************
  wire [4:0] ref_to_if_ratio   = clock_reg[`F_RATIO_HI:`F_RATIO_LO];
  wire [4:0] clockgen_prescale = clock_reg[`F_PRE_HI:`F_PRE_LO];
  wire [6:0] data_rate_divider = clock_reg[`F_DRD_HI:`F_DRD_LO];
  wire       clockgen_select   = clock_reg[`F_CGSEL];
  wire       clockgen_ref_sel  = clock_reg[`F_REFSEL];
  wire       osc_enable        = clock_reg[`F_OSCEN];
  wire       chip_bias_enable  = mode_reg[`F_BIAS];
  wire       synth_enable      = mode_reg[`F_SYNTH];
  wire       trx_request       = mode_reg[`F_TRX];
  wire [2:0] settle_delay_select = synth1[`F_SETTLE_HI:`F_SETTLE_LO];

  // ************************************************************
  // power pin synchroniser
  // ************************************************************
  reg [2:0] pwr_sync;
  reg       power_on;

  // three stages; the level changes only when the last two agree
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pwr_sync <= 3'b000;
      power_on <= 1'b0;
    end else begin
      pwr_sync <= {pwr_sync[1:0], power_on_pin};
      if (pwr_sync[2] == pwr_sync[1]) power_on <= pwr_sync[2];
    end
  end

  // ************************************************************
  // clock source and dividers
  // ************************************************************
  // oscillator or generator source, picked by clockgen_select
  assign source_tick = clockgen_select ? pll_tick : osc_tick;
  assign adc_tick = source_tick;

  clk_divider #(.W(5)) u_prescale (
    .mclk (mclk),
    .rstn (rstn),
    .en   (clockgen_select && osc_on),
    .div  (clockgen_prescale),
    .tick (clockgen_tick)
  );

  // IF divides the (ratio+1) output by 64
  // a gated counter here, since the shared divider reloads whenever its
  // enable drops, and source ticks leave gaps between them
  reg  [5:0] if_count;
  reg  [4:0] ratio_cnt;
  reg        ratio_hit;
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ratio_cnt <= 5'h00;
      ratio_hit <= 1'b0;
      if_count  <= 6'h00;
    end else begin
      ratio_hit <= 1'b0;
      if (source_tick) begin
        if (ratio_cnt >= ref_to_if_ratio) begin
          ratio_cnt <= 5'h00;
          ratio_hit <= 1'b1;
        end else begin
          ratio_cnt <= ratio_cnt + 5'h01;
        end
      end
      if (ratio_hit) if_count <= if_count + 6'h01;
    end
  end
  assign if_tick = ratio_hit && (if_count == 6'h3f);

  reg [6:0] dr_cnt;
  reg [6:0] dr_post;
  reg       dr_hit;
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dr_cnt  <= 7'h00;
      dr_post <= 7'h00;
      dr_hit  <= 1'b0;
    end else begin
      dr_hit <= 1'b0;
      if (source_tick) begin
        if (dr_cnt >= data_rate_divider) begin
          dr_cnt <= 7'h00;
          dr_hit <= 1'b1;
        end else begin
          dr_cnt <= dr_cnt + 7'h01;
        end
      end
      if (dr_hit) dr_post <= dr_post + 7'h01;
    end
  end
  assign data_rate_tick = dr_hit && (dr_post == 7'h7f);

  // ************************************************************
  // power state machine
  // ************************************************************
  reg [15:0] settle_cnt;
  reg [2:0]  settle_units;
  assign consume = (power_state == ST_WAIT) && synth_changed &&
                   (settle_cnt == 16'h0000) && (settle_units == 3'h0);

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      power_state  <= ST_SLEEP;
      settle_cnt   <= 16'h0000;
      settle_units <= 3'h0;
      trx_ready    <= 1'b0;
    end else begin
      trx_ready <= 1'b0;
      case (power_state)
        ST_SLEEP: begin
          if (power_on) power_state <= ST_STANDBY;
        end
        ST_STANDBY: begin
          if (!power_on) begin
            power_state <= ST_SLEEP;
          end else if (trx_request) begin
            power_state  <= ST_WAIT;
            settle_cnt   <= SETTLE_UNIT_CYC[15:0];
            settle_units <= settle_delay_select;
          end
        end
        ST_WAIT: begin
          if (!power_on) begin
            power_state <= ST_SLEEP;
          end else if (!synth_changed) begin
            power_state <= ST_TRX;
          end else if (settle_cnt != 16'h0000) begin
            settle_cnt <= settle_cnt - 16'h0001;
          end else if (settle_units != 3'h0) begin
            settle_units <= settle_units - 3'h1;
            settle_cnt   <= SETTLE_UNIT_CYC[15:0];
          end else begin
            power_state <= ST_TRX;
          end
        end
        ST_TRX: begin
          trx_ready <= 1'b1;
          if (!power_on) power_state <= ST_SLEEP;
          else if (!trx_request) power_state <= ST_STANDBY;
        end
        default: power_state <= ST_SLEEP;
      endcase
    end
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      osc_on             <= 1'b0;
      bandgap_on         <= 1'b0;
      pll_on             <= 1'b0;
      clockgen_on        <= 1'b0;
      clockgen_reference <= 1'b0;
    end else begin
      osc_on      <= (power_state != ST_SLEEP) &&
                     (chip_bias_enable || synth_enable || power_state != ST_STANDBY) &&
                     osc_enable;
      bandgap_on  <= (power_state != ST_SLEEP) &&
                     (chip_bias_enable || synth_enable || power_state != ST_STANDBY);
      pll_on      <= (power_state != ST_SLEEP) &&
                     (synth_enable || power_state != ST_STANDBY);
      clockgen_on <= (power_state != ST_SLEEP) && clockgen_select;
      clockgen_reference <= clockgen_ref_sel;
    end
  end
endmodule
`default_nettype wire

/* tb/clk_setup_props.sv */
// Purpose: port assertions for clk_setup
// Assumes: one clock domain, async active-low reset
// Notes:   bound to every clk_setup instance
`timescale 1ns/1ps
`default_nettype none
// ********
// checker
// ********
module clk_setup_props (
  // clock and reset
  input wire logic       mclk,
  input wire logic       rstn,
  // watched ports
  input wire logic       osc_tick,
  input wire logic       pll_tick,
  input wire logic       power_on_pin,
  input wire logic       bandgap_on,
  input wire logic       pll_on,
  input wire logic       source_tick,
  input wire logic       adc_tick,
  input wire logic       if_tick,
  input wire logic [1:0] power_state
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // pin synchroniser and state register leave some edges of slack
  a_sleep_pin: assert property (!power_on_pin [*7] |-> power_state == 2'd0)
    else $error("not asleep");
  a_wake_standby: assert property ($rose(power_on_pin) |-> ##[1:8] power_state == 2'd1)
    else $error("no wake");
  a_adc_source: assert property (adc_tick == source_tick)
    else $error("adc tick off source");
  a_src_cause: assert property (source_tick |-> osc_tick || pll_tick)
    else $error("source tick uncaused");
  a_pll_bias: assert property (pll_on |-> bandgap_on)
    else $error("pll without bias");
  a_if_gap: assert property (if_tick |=> !if_tick [*8])
    else $error("if ticks too close");
  a_trx_path: assert property (power_state == 2'd3 && $past(power_state) != 2'd3 |->
    $past(power_state) == 2'd2)
    else $error("trx not via wait");
  a_wait_bound: assert property (power_state == 2'd2 |-> ##[0:60] power_state != 2'd2)
    else $error("wait too long");
  c_trx: cover property (power_state == 2'd3);
  c_pll: cover property (pll_tick && source_tick);
  c_if: cover property (if_tick);
endmodule
bind clk_setup clk_setup_props props (.mclk(mclk), .rstn(rstn), .osc_tick(osc_tick),
  .pll_tick(pll_tick), .power_on_pin(power_on_pin), .bandgap_on(bandgap_on),
  .pll_on(pll_on), .source_tick(source_tick), .adc_tick(adc_tick), .if_tick(if_tick),
  .power_state(power_state));
`default_nettype wire

/* tb/ref_source.sv */
// Purpose: crystal and clock generator model
// Assumes: ticks are one-cycle strobes on mclk
// Notes:   silent while the block keeps it off
`timescale 1ns/1ps
`default_nettype none
module ref_source (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rstn,
  // enables and bench rate
  input  wire logic       osc_on,
  input  wire logic       clockgen_on,
  input  wire logic [3:0] osc_div,
  // strobes
  output var  logic       osc_tick,
  output var  logic       pll_tick
);
  logic [3:0] oc;
  always @(posedge mclk or negedge rstn) begin
    if (!rstn || !osc_on) begin
      oc       <= 4'h0;
      osc_tick <= 1'b0;
    end else begin
      oc       <= (oc + 4'h1 >= osc_div) ? 4'h0 : oc + 4'h1;
      osc_tick <= (oc == 4'h0);
    end
  end
  always @(posedge mclk or negedge rstn) begin
    if (!rstn || !clockgen_on)
      pll_tick <= 1'b0;
    else
      pll_tick <= !pll_tick;
  end
endmodule
`default_nettype wire

/* tb/clk_setup_test.sv */
// Purpose: self-checking bench for clk_setup
// Assumes: settle unit shortened to 4 cycles
// Notes:   drivers note results in queues, a monitor pops them
`timescale 1ns/1ps
`default_nettype none
// *****
// bench
// *****
module clk_setup_test;
  logic        mclk, rstn, read, write, power_on_pin, waitrequest, osc_tick, pll_tick;
  logic        osc_on, bandgap_on, pll_on, clockgen_on, clockgen_reference, source_tick;
  logic        adc_tick, clockgen_tick, if_tick, data_rate_tick, trx_ready;
  logic [1:0]  power_state;
  logic [3:0]  byteenable, osc_div;
  logic [7:0]  address;
  logic [31:0] writedata, readdata, v, lo;
  logic [31:0] seed = 32'h9373;
  logic [31:0] rd_q[$], if_q[$], dr_q[$], cg_q[$], w_q[$];
  int          n_mismatch, n_compared, cyc, c_if, c_dr, c_cg, c_w, p_st;
  // register offsets, writable bits, prescale table rows
  logic [7:0]  ofs[5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14};
  logic [31:0] msk[5] = '{32'h077f1f1f, 32'h71f, 32'hff, 32'hffff, 32'h3};
  logic [4:0]  pre[5] = '{5'd15, 5'd4, 5'd14, 5'd19, 5'd4};
  logic [4:0]  rs     = 5'h10;
  logic [4:0]  cs     = 5'h1e;
  clk_setup #(.SETTLE_UNIT_CYC(4)) dut (.mclk(mclk), .rstn(rstn), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .osc_tick(osc_tick),
    .pll_tick(pll_tick), .power_on_pin(power_on_pin), .osc_on(osc_on),
    .bandgap_on(bandgap_on), .pll_on(pll_on), .clockgen_on(clockgen_on),
    .clockgen_reference(clockgen_reference), .source_tick(source_tick),
    .adc_tick(adc_tick), .clockgen_tick(clockgen_tick), .if_tick(if_tick),
    .data_rate_tick(data_rate_tick), .power_state(power_state), .trx_ready(trx_ready));
  ref_source src (.mclk(mclk), .rstn(rstn), .osc_on(osc_on), .clockgen_on(clockgen_on),
    .osc_div(osc_div), .osc_tick(osc_tick), .pll_tick(pll_tick));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be, input logic [31:0] e);
    @(posedge mclk);
    if (!w) rd_q.push_back(e);
    read       <= !w;
    write      <= w;
    address    <= a;
    writedata  <= d;
    byteenable <= be;
    do @(posedge mclk); while (waitrequest);
    read  <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf, 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hf, e);
  endtask
  // skip the partial window, then note two full ones
  task automatic period(input int k, input logic [31:0] e);
    int t;
    t = 0;
    do begin
      @(negedge mclk);
      t++;
    end while (!(k == 0 ? if_tick : k == 1 ? data_rate_tick : clockgen_tick) && t < 9000);
    @(negedge mclk);
    repeat (2) begin
      if (k == 0) if_q.push_back(e);
      else if (k == 1) dr_q.push_back(e);
      else cg_q.push_back(e);
    end
    while (if_q.size() + dr_q.size() + cg_q.size() > 0) @(posedge mclk);
  endtask
  task automatic wst(input logic [1:0] s);
    int t;
    t = 0;
    while (power_state !== s && t < 300) begin
      @(posedge mclk);
      t++;
    end
    compare({30'h0, power_state}, {30'h0, s});
  endtask
  task automatic done(input string s);
    $display("test %s ended", s);
  endtask
  task automatic results;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // monitor: counts source ticks and cycles, checks what appears
  always @(posedge mclk) begin
    c_if = c_if + source_tick;
    c_dr = c_dr + source_tick;
    c_cg = c_cg + 1;
    if (read && !waitrequest) compare(readdata, rd_q.pop_front());
    if (if_tick && if_q.size() > 0) compare(c_if, if_q.pop_front());
    if (data_rate_tick && dr_q.size() > 0) compare(c_dr, dr_q.pop_front());
    if (clockgen_tick && cg_q.size() > 0) compare(c_cg, cg_q.pop_front());
    if (power_state == 2'd3 && p_st != 3 && w_q.size() > 0) begin
      lo = w_q.pop_front();
      compare(c_w >= lo && c_w <= lo + 10, 32'h1);
    end
    if (if_tick) c_if = 0;
    if (data_rate_tick) c_dr = 0;
    if (clockgen_tick) c_cg = 0;
    c_w = (power_state == 2'd2) ? c_w + 1 : 0;
    p_st = power_state;
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end
  // main sequence
  initial begin
    rstn = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 8'h0;
    writedata = 32'h0;
    byteenable = 4'h0;
    power_on_pin = 1'b0;
    osc_div = 4'h1;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    for (int a = 0; a < 8; a++) rd(8'(a * 4), 32'h0);
    done("reset");
    power_on_pin <= 1'b1;
    wst(2'd1);
    wr(8'h00, 32'h0400_0000);
    // no enable, bias only, synth only in standby, seen through status
    for (int m = 0; m < 3; m++) begin
      wr(8'h14, m);
      repeat (3) @(posedge mclk);
      compare({31'h0, bandgap_on}, {31'h0, (m != 0)});
      rd(8'h18, m == 0 ? 32'h1 : m == 1 ? 32'h5 : 32'hd);
    end
    // external reference: oscillator off, PLL still on
    wr(8'h00, 32'h0);
    repeat (3) @(posedge mclk);
    rd(8'h18, 32'h9);
    // random fields read back within their width
    for (int i = 0; i < 5; i++) begin
      v = (xs() | 32'h0400_0000) & msk[i];
      wr(ofs[i], v);
      rd(ofs[i], v);
    end
    wr(8'h0c, 32'h0);
    bus(1'b1, 8'h0c, 32'hffff_ffff, 4'h2, 32'h0);
    rd(8'h0c, 32'hff00);
    wr(8'h1c, xs());
    rd(8'h1c, 32'h0);
    done("registers");
    wr(8'h14, 32'h1);
    // prescale rows, oscillator ticking every cycle
    for (int k = 0; k < 5; k++) begin
      wr(8'h00, 32'h0400_0000 | {rs[k], cs[k], 11'h0, pre[k], 8'h0});
      repeat (4) @(posedge mclk);
      compare({31'h0, clockgen_on}, {31'h0, cs[k]});
      if (cs[k]) begin
        compare({31'h0, clockgen_reference}, {31'h0, rs[k]});
        period(2, pre[k] + 1);
      end
    end
    // each ratio picks an IF rate matched to the data rate
    // direct-mode data is paced by data_rate_tick
    // dividers fed by the oscillator, then by the generator
    for (int k = 0; k < 2; k++) begin
      osc_div <= k ? 4'h1 : 4'h3;
      wr(8'h00, k ? 32'h0702_0400 : 32'h0401_0001);
      period(0, k ? 64 : 128);
      period(1, k ? 384 : 256);
    end
    done("dividers");
    // ref_divider 0 keeps the compare rate far above the data rate
    wr(8'h04, 32'h0000_0310);
    wr(8'h08, 32'h0000_0044);
    // first entry settles after the synth change, second passes straight
    for (int k = 0; k < 2; k++) begin
      w_q.push_back(k ? 0 : 16);
      wr(8'h14, 32'h7);
      wst(2'd3);
      rd(8'h18, 32'h1f);
      wr(8'h14, 32'h3);
      wst(2'd1);
    end
    done("settle");
    power_on_pin <= 1'b0;
    wst(2'd0);
    done("sleep");
    results();
  end
endmodule
`default_nettype wire
